//--- hdl/hpsrp_cfg.svh
// Purpose: offsets, field positions, reset values for the host strobe/request pin block
// Assumes: 3-bit register address, 8-bit register data
// Notes:   register offsets, widths, control/status field positions and reset values live here
`ifndef HPSRP_CFG_SVH
`define HPSRP_CFG_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define HPSRP_ADDR_W         3
`define HPSRP_DATA_W         8
`define HPSRP_PINS           3
`define HPSRP_OFF_CTRL       3'h0
`define HPSRP_OFF_PORTSEL    3'h1
`define HPSRP_OFF_DIR        3'h2
`define HPSRP_OFF_GPOUT      3'h3
`define HPSRP_OFF_STAT       3'h4

// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define HPSRP_CTRL_DBL_STB   0
`define HPSRP_CTRL_DBL_REQ   1
`define HPSRP_CTRL_STB_POL   2
`define HPSRP_CTRL_REQ_POL   3
`define HPSRP_CTRL_ACK_POL   4
`define HPSRP_CTRL_OPEN_DR   5
`define HPSRP_CTRL_RX_EN     6
`define HPSRP_CTRL_TX_EN     7

// ----------------------------------------------------------------------------
// status fields (pin levels sit in bits 2:0)
// ----------------------------------------------------------------------------
`define HPSRP_STAT_STB       3
`define HPSRP_STAT_ACK       4
`define HPSRP_STAT_STOP      5
`define HPSRP_STAT_WAIT      6
`define HPSRP_STAT_REQ       7

// ----------------------------------------------------------------------------
// reset values: polarities active low, host function selected, port bits all inputs
// ----------------------------------------------------------------------------
`define HPSRP_RST_CTRL       8'h00
`define HPSRP_RST_PORTSEL    8'h00
`define HPSRP_RST_DIR        8'h00
`define HPSRP_RST_GPOUT      8'h00
`define HPSRP_RST_PIN        3'h7

`endif

//--- hdl/hpsrp_pkg.sv
// Purpose: types of the host strobe/request pin block
// Assumes: nothing
// Notes:   pin function per physical pin
package hpsrp_pkg;

    typedef enum logic [2:0]
    {
        FN_GPIO,
        FN_STROBE_IN,
        FN_REQ_OUT,
        FN_ACK_IN,
        FN_RXREQ_OUT
    } hpsrp_func_t;

endpackage : hpsrp_pkg

//--- hdl/hpsrp_sync.sv
// Purpose: two-flop synchroniser for the host pins
// Assumes: inputs are asynchronous to clock_i
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`include "hpsrp_cfg.svh"

module hpsrp_sync
(
    input  wire logic                   clock_i,
    input  wire logic                   rstn_i,
    input  wire logic                   ce_i,
    input  wire logic [`HPSRP_PINS-1:0] async_i,
    output logic      [`HPSRP_PINS-1:0] sync_o
);

    logic [`HPSRP_PINS-1:0] meta;

    genvar g;
    generate
        for (g = 0; g < `HPSRP_PINS; g = g + 1)
        begin : g_bit
            // idle pin level is high: inactive for the default active-low use
            always_ff @(posedge clock_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    meta[g]   <= 1'b1;
                    sync_o[g] <= 1'b1;
                end
                else if (ce_i)
                begin
                    meta[g]   <= async_i[g];
                    sync_o[g] <= meta[g];
                end
            end
        end
    endgenerate

endmodule : hpsrp_sync

//--- hdl/hpsrp_top.sv
// Purpose: strobe, request and acknowledge pins of an 8-bit parallel host port
// Assumes: single clock, register port in the same domain, pins asynchronous
// Notes:   pin 0 strobe / port bit 12, pin 1 request / port bit 14,
//          pin 2 acknowledge or receive request / port bit 15
//
// Overview of operation
// - single strobe mode: pin 0 is data strobe input, polarity reset low
// - double strobe mode: pin 0 is write strobe input, polarity reset low
// - port select turns pins into port bits, direction per bit register
// - single request mode: pin 1 drives host request, polarity reset low
// - request outputs selectable together as driven or open drain by one control bit
// - double request mode: pin 1 drives transmit request, polarity reset low
// - double request mode: pin 2 drives receive request, polarity reset low
// - single request mode: pin 2 is acknowledge input, polarity reset low
// - in stop, input pins are ignored
// - in stop, last output level kept by weak keeper, driver released
// - wait state changes no pin
`timescale 1ns/1ps
`include "hpsrp_cfg.svh"

module hpsrp_top
(
    input  wire logic                     clock_i,
    input  wire logic                     rstn_i,
    input  wire logic                     ce_i,
    // register port
    input  wire logic [`HPSRP_ADDR_W-1:0] addr_i,
    input  wire logic [`HPSRP_DATA_W-1:0] wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    output logic      [`HPSRP_DATA_W-1:0] rdata_o,
    // host port core side
    input  wire logic                     rx_request_i,
    input  wire logic                     tx_request_i,
    input  wire logic                     stop_i,
    input  wire logic                     wait_i,
    output logic                          data_strobe_o,
    output logic                          write_strobe_o,
    output logic                          strobe_start_o,
    output logic                          acknowledge_o,
    output logic                          acknowledge_start_o,
    // pin 0: strobe / port bit 12
    input  wire logic                     strobe_pin_i,
    output logic                          strobe_pin_o,
    output logic                          strobe_pin_oe_n_o,
    output logic                          strobe_pin_keep_o,
    // pin 1: request / transmit request / port bit 14
    input  wire logic                     request_pin_i,
    output logic                          request_pin_o,
    output logic                          request_pin_oe_n_o,
    output logic                          request_pin_keep_o,
    // pin 2: acknowledge / receive request / port bit 15
    input  wire logic                     ack_pin_i,
    output logic                          ack_pin_o,
    output logic                          ack_pin_oe_n_o,
    output logic                          ack_pin_keep_o
);

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [`HPSRP_DATA_W-1:0] ctrl;
    logic [`HPSRP_DATA_W-1:0] portsel;
    logic [`HPSRP_DATA_W-1:0] dir;
    logic [`HPSRP_DATA_W-1:0] gpout;
    logic [`HPSRP_PINS-1:0]   pin_seen;

    wire dbl_strobe = ctrl[`HPSRP_CTRL_DBL_STB];
    wire dbl_req    = ctrl[`HPSRP_CTRL_DBL_REQ];
    wire strobe_pol = ctrl[`HPSRP_CTRL_STB_POL];
    wire req_pol    = ctrl[`HPSRP_CTRL_REQ_POL];
    wire ack_pol    = ctrl[`HPSRP_CTRL_ACK_POL];
    wire open_drain = ctrl[`HPSRP_CTRL_OPEN_DR];
    wire rx_en      = ctrl[`HPSRP_CTRL_RX_EN];
    wire tx_en      = ctrl[`HPSRP_CTRL_TX_EN];
    wire gpio_sel   = portsel[0];

    wire wr_ctrl    = wr_i && (addr_i == `HPSRP_OFF_CTRL);
    wire wr_portsel = wr_i && (addr_i == `HPSRP_OFF_PORTSEL);
    wire wr_dir     = wr_i && (addr_i == `HPSRP_OFF_DIR);
    wire wr_gpout   = wr_i && (addr_i == `HPSRP_OFF_GPOUT);

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl    <= `HPSRP_RST_CTRL;
            portsel <= `HPSRP_RST_PORTSEL;
            dir     <= `HPSRP_RST_DIR;
            gpout   <= `HPSRP_RST_GPOUT;
        end
        else if (ce_i)
        begin
            if (wr_ctrl)
                ctrl <= wdata_i;
            if (wr_portsel)
                portsel <= wdata_i;
            if (wr_dir)
                dir <= wdata_i;
            if (wr_gpout)
                gpout <= wdata_i;
        end
    end

    // ------------------------------------------------------------------------
    // pin input synchronisation
    // ------------------------------------------------------------------------
    logic [`HPSRP_PINS-1:0] pin_sync;

    hpsrp_sync u_sync
    (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .ce_i    (ce_i),
        .async_i ({ack_pin_i, request_pin_i, strobe_pin_i}),
        .sync_o  (pin_sync)
    );

    // inputs are frozen in stop so software sees the last value, not noise
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pin_seen <= `HPSRP_RST_PIN;
        else if (ce_i && !stop_i)
            pin_seen <= pin_sync;
    end

    // ------------------------------------------------------------------------
    // pin function selection
    // ------------------------------------------------------------------------
    hpsrp_pkg::hpsrp_func_t func [`HPSRP_PINS];

    // one function per pin, port select overrides every host function
    assign func[0] = gpio_sel ? hpsrp_pkg::FN_GPIO : hpsrp_pkg::FN_STROBE_IN;
    assign func[1] = gpio_sel ? hpsrp_pkg::FN_GPIO : hpsrp_pkg::FN_REQ_OUT;
    assign func[2] = gpio_sel ? hpsrp_pkg::FN_GPIO :
                     (dbl_req ? hpsrp_pkg::FN_RXREQ_OUT : hpsrp_pkg::FN_ACK_IN);

    // ------------------------------------------------------------------------
    // strobe and acknowledge inputs
    // ------------------------------------------------------------------------
    wire strobe_hit = (func[0] == hpsrp_pkg::FN_STROBE_IN) && !stop_i
                      && (pin_sync[0] == strobe_pol);
    wire host_data_strobe_in  = strobe_hit && !dbl_strobe;
    wire host_write_strobe_in = strobe_hit && dbl_strobe;
    // host must drive this at the programmed level to answer a request
    wire host_acknowledge_in  = (func[2] == hpsrp_pkg::FN_ACK_IN) && !stop_i
                                && (pin_sync[2] == ack_pol);

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            data_strobe_o       <= 1'b0;
            write_strobe_o      <= 1'b0;
            strobe_start_o      <= 1'b0;
            acknowledge_o       <= 1'b0;
            acknowledge_start_o <= 1'b0;
        end
        else if (ce_i)
        begin
            data_strobe_o       <= host_data_strobe_in;
            write_strobe_o      <= host_write_strobe_in;
            strobe_start_o      <= strobe_hit && !(data_strobe_o || write_strobe_o);
            acknowledge_o       <= host_acknowledge_in;
            acknowledge_start_o <= host_acknowledge_in && !acknowledge_o;
        end
    end

    // ------------------------------------------------------------------------
    // request outputs
    // ------------------------------------------------------------------------
    wire req_any              = (rx_request_i && rx_en) || (tx_request_i && tx_en);
    wire host_request_out     = !dbl_req && req_any;
    wire transmit_request_out = dbl_req && tx_request_i && tx_en;
    wire receive_request_out  = dbl_req && rx_request_i && rx_en;

    wire pin1_active = dbl_req ? transmit_request_out : host_request_out;
    wire pin1_level  = pin1_active ? req_pol : !req_pol;
    wire pin2_level  = receive_request_out ? req_pol : !req_pol;

    // ------------------------------------------------------------------------
    // per-pin driver resolution
    // ------------------------------------------------------------------------
    logic [`HPSRP_PINS-1:0] req_level;
    logic [`HPSRP_PINS-1:0] want_val;
    logic [`HPSRP_PINS-1:0] want_en;
    logic [`HPSRP_PINS-1:0] pin_out;
    logic [`HPSRP_PINS-1:0] pin_oe_n;
    logic [`HPSRP_PINS-1:0] pin_keep;

    assign req_level = {pin2_level, pin1_level, 1'b1};

    genvar g;
    generate
        for (g = 0; g < `HPSRP_PINS; g = g + 1)
        begin : g_pin
            wire is_gpio = (func[g] == hpsrp_pkg::FN_GPIO);
            wire is_req  = (func[g] == hpsrp_pkg::FN_REQ_OUT)
                           || (func[g] == hpsrp_pkg::FN_RXREQ_OUT);
            // open drain only pulls low; a high level is left to the pull-up
            wire req_en  = open_drain ? !req_level[g] : 1'b1;
            wire req_val = open_drain ? 1'b0 : req_level[g];

            assign want_en[g]  = is_gpio ? dir[g] : (is_req ? req_en : 1'b0);
            assign want_val[g] = is_gpio ? gpout[g] : (is_req ? req_val : 1'b1);

            // wait_i deliberately plays no part here
            always_ff @(posedge clock_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    pin_out[g]  <= 1'b1;
                    pin_oe_n[g] <= 1'b1;
                    pin_keep[g] <= 1'b0;
                end
                else if (ce_i)
                begin
                    if (stop_i)
                    begin
                        // driver off, keeper holds whatever was last driven
                        pin_oe_n[g] <= 1'b1;
                        pin_keep[g] <= pin_keep[g] || !pin_oe_n[g];
                    end
                    else
                    begin
                        pin_out[g]  <= want_val[g];
                        pin_oe_n[g] <= !want_en[g];
                        pin_keep[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign strobe_pin_o       = pin_out[0];
    assign strobe_pin_oe_n_o  = pin_oe_n[0];
    assign strobe_pin_keep_o  = pin_keep[0];
    assign request_pin_o      = pin_out[1];
    assign request_pin_oe_n_o = pin_oe_n[1];
    assign request_pin_keep_o = pin_keep[1];
    assign ack_pin_o          = pin_out[2];
    assign ack_pin_oe_n_o     = pin_oe_n[2];
    assign ack_pin_keep_o     = pin_keep[2];

    // ------------------------------------------------------------------------
    // read back
    // ------------------------------------------------------------------------
    logic [`HPSRP_DATA_W-1:0] stat;
    logic [`HPSRP_DATA_W-1:0] rd_mux;

    // wait is only reported; it changes no pin
    assign stat = {pin1_active || receive_request_out,
                   wait_i,
                   stop_i,
                   acknowledge_o,
                   data_strobe_o || write_strobe_o,
                   pin_seen};

    assign rd_mux = (addr_i == `HPSRP_OFF_CTRL)    ? ctrl    :
                    (addr_i == `HPSRP_OFF_PORTSEL) ? portsel :
                    (addr_i == `HPSRP_OFF_DIR)     ? dir     :
                    (addr_i == `HPSRP_OFF_GPOUT)   ? gpout   :
                    (addr_i == `HPSRP_OFF_STAT)    ? stat    :
                    8'h00;

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_o <= 8'h00;
        else if (ce_i)
            rdata_o <= rd_i ? rd_mux : 8'h00;
    end

endmodule : hpsrp_top

//--- tb/hpsrp_host_model.sv
// Purpose: host processor on the far side of the strobe/request pins
// Assumes: pull-ups on all three pins
// Notes:   answers a request with acknowledge when auto_ack_i is high
`timescale 1ns/1ps

module hpsrp_host_model
(
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    input  wire logic       auto_ack_i,
    input  wire logic       ack_pol_i,
    input  wire logic       req_pol_i,
    input  wire logic       strobe_lvl_i,
    input  wire logic [2:0] dev_o_i,
    input  wire logic [2:0] dev_oe_n_i,
    output logic      [2:0] pin_o
);
    // ------------------------------------------------------------
    // wire resolution
    // ------------------------------------------------------------
    logic ack_on;

    // host yields a pin the device drives; released pin 1 floats to the pull-up, pins 0 and 2 take the host strobe and acknowledge levels
    assign pin_o[0] = dev_oe_n_i[0] ? strobe_lvl_i : dev_o_i[0];
    assign pin_o[1] = dev_oe_n_i[1] ? 1'b1 : dev_o_i[1];
    assign pin_o[2] = dev_oe_n_i[2] ? (ack_on ? ack_pol_i : !ack_pol_i) : dev_o_i[2];

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ack_on <= 1'b0;
        else
            ack_on <= auto_ack_i && (pin_o[1] == req_pol_i);
    end
endmodule : hpsrp_host_model

//--- tb/hpsrp_monitor.sv
// Purpose: port checker for the host strobe/request pin block
// Assumes: shadows of control, port select, direction and output registers
// Notes:   bound to hpsrp_top at the foot of this file
`timescale 1ns/1ps
`include "hpsrp_cfg.svh"

module hpsrp_monitor
(
    input  wire logic                     clock_i,
    input  wire logic                     rstn_i,
    input  wire logic                     ce_i,
    input  wire logic [`HPSRP_ADDR_W-1:0] addr_i,
    input  wire logic [`HPSRP_DATA_W-1:0] wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rx_request_i,
    input  wire logic                     tx_request_i,
    input  wire logic                     stop_i,
    input  wire logic                     data_strobe_o,
    input  wire logic                     write_strobe_o,
    input  wire logic                     strobe_start_o,
    input  wire logic                     acknowledge_o,
    input  wire logic                     acknowledge_start_o,
    input  wire logic                     request_pin_o,
    input  wire logic                     request_pin_oe_n_o,
    input  wire logic                     request_pin_keep_o,
    input  wire logic                     ack_pin_o,
    input  wire logic                     ack_pin_oe_n_o
);
    // ------------------------------------------------------------
    // expected pin state, one edge behind the registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic       sel_q, dir_q, out_q, drv_q, od_q, rxd_q, gp_q, e1_q, e2_q, gd_q, go_q;
    wire        wr_ctl = wr_i && addr_i == `HPSRP_OFF_CTRL;
    wire        tx_on  = tx_request_i && ctrl_q[7];
    wire        rx_on  = rx_request_i && ctrl_q[6];
    wire        act1   = ctrl_q[1] ? tx_on : (tx_on || rx_on);
    wire        host   = !sel_q && !stop_i;

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            {ctrl_q, sel_q, dir_q, out_q, drv_q, od_q, rxd_q, gp_q, e1_q, e2_q, gd_q, go_q} <= '0;
        else if (ce_i)
        begin
            ctrl_q <= wr_ctl ? wdata_i : ctrl_q;
            sel_q  <= (wr_i && addr_i == `HPSRP_OFF_PORTSEL) ? wdata_i[0] : sel_q;
            dir_q  <= (wr_i && addr_i == `HPSRP_OFF_DIR) ? wdata_i[1] : dir_q;
            out_q  <= (wr_i && addr_i == `HPSRP_OFF_GPOUT) ? wdata_i[1] : out_q;
            drv_q  <= host && !ctrl_q[5];
            od_q   <= host && ctrl_q[5];
            rxd_q  <= host && ctrl_q[1] && !ctrl_q[5];
            gp_q   <= sel_q && !stop_i;
            e1_q   <= act1 ? ctrl_q[3] : !ctrl_q[3];
            e2_q   <= rx_on ? ctrl_q[3] : !ctrl_q[3];
            gd_q   <= dir_q;
            go_q   <= out_q;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    start_pulse_a: assert property (
        strobe_start_o |-> (data_strobe_o || write_strobe_o) ##1 !strobe_start_o)
        else $error("strobe start pulse wrong");
    one_strobe_a: assert property (!(data_strobe_o && write_strobe_o))
        else $error("both strobe functions active");
    ack_input_a: assert property (acknowledge_o |-> ack_pin_oe_n_o)
        else $error("acknowledge seen on a driven pin");
    req_drive_a: assert property (
        drv_q |-> !request_pin_oe_n_o && request_pin_o == e1_q)
        else $error("request pin level wrong");
    open_drain_a: assert property (
        od_q |-> !request_pin_o && request_pin_oe_n_o == e1_q)
        else $error("open drain request wrong");
    rx_request_a: assert property (
        rxd_q |-> !ack_pin_oe_n_o && ack_pin_o == e2_q)
        else $error("receive request pin wrong");
    gpio_dir_a: assert property (
        gp_q |-> request_pin_oe_n_o == !gd_q && request_pin_o == go_q)
        else $error("port bit drive wrong");
    stop_off_a: assert property (
        $past(stop_i) && $past(ce_i) |-> request_pin_oe_n_o && ack_pin_oe_n_o)
        else $error("driver not released in stop");
    stop_hold_a: assert property (
        $past(stop_i, 2) && $past(stop_i) |-> $stable(request_pin_o) && $stable(request_pin_keep_o))
        else $error("kept level moved in stop");
    stop_ignore_a: assert property (
        $past(stop_i) && $past(ce_i) |-> !data_strobe_o && !write_strobe_o && !acknowledge_o)
        else $error("input seen in stop");
    ack_start_a: assert property (
        acknowledge_start_o |-> acknowledge_o ##1 !acknowledge_start_o)
        else $error("acknowledge start pulse wrong");

    cover property (acknowledge_o);
    cover property (request_pin_keep_o);
    cover property (strobe_start_o && write_strobe_o);
endmodule : hpsrp_monitor

bind hpsrp_top hpsrp_monitor mon (.clock_i, .rstn_i, .ce_i, .addr_i, .wdata_i, .wr_i,
    .rx_request_i, .tx_request_i, .stop_i, .data_strobe_o, .write_strobe_o, .strobe_start_o,
    .acknowledge_o, .acknowledge_start_o, .request_pin_o, .request_pin_oe_n_o,
    .request_pin_keep_o, .ack_pin_o,
    .ack_pin_oe_n_o);

//--- tb/hpsrp_tb_top.sv
// Purpose: self-checking bench for the host strobe/request pin block
// Assumes: ce_i high except in the freeze check, host model on the pins
// Notes:   register values are written as plain bytes per field map
`timescale 1ns/1ps

module hpsrp_tb_top;
    // ------------------------------------------------------------
    // stimulus, design and host
    // ------------------------------------------------------------
    logic       clock_i = 0, rstn_i = 0, wr = 0, rd = 0, rx = 0, tx = 0, stp = 0, wt = 0;
    logic       slvl = 1, auto = 0, apol = 0, rpol = 0, ce = 1;
    logic [2:0] addr = '0;
    logic [7:0] wdata = '0, rdata, rv;
    logic       ds, ws, ak, s_o, s_oe, s_k, r_o, r_oe, r_k, a_o, a_oe, a_k;
    wire  [2:0] pin;
    int         errors = 0, n_checks = 0, cyc = 0;

    always #4 clock_i = !clock_i;

    hpsrp_top dut (.clock_i, .rstn_i, .ce_i(ce), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .rx_request_i(rx), .tx_request_i(tx), .stop_i(stp),
        .wait_i(wt), .data_strobe_o(ds), .write_strobe_o(ws), .strobe_start_o(),
        .acknowledge_o(ak), .acknowledge_start_o(), .strobe_pin_i(pin[0]), .strobe_pin_o(s_o),
        .strobe_pin_oe_n_o(s_oe), .strobe_pin_keep_o(s_k), .request_pin_i(pin[1]),
        .request_pin_o(r_o), .request_pin_oe_n_o(r_oe), .request_pin_keep_o(r_k),
        .ack_pin_i(pin[2]), .ack_pin_o(a_o), .ack_pin_oe_n_o(a_oe), .ack_pin_keep_o(a_k));
    hpsrp_host_model host (.clock_i, .rstn_i, .auto_ack_i(auto), .ack_pol_i(apol),
        .req_pol_i(rpol), .strobe_lvl_i(slvl), .dev_o_i({a_o, r_o, s_o}),
        .dev_oe_n_i({a_oe, r_oe, s_oe}), .pin_o(pin));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : step

    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock_i);
        wr <= 1'b0;
        // leave the edge so the caller's next drive cannot race the flops
        #1;
    endtask : wreg

    task automatic rreg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rreg

    task automatic t_reset;
        rreg(3'h0, rv);
        chk(rv, 8'h00);
        rreg(3'h5, rv);
        chk(rv, 8'h00);
        chk(8'({r_oe, r_o}), 8'h01);
        slvl = 1'b0;
        step(5);
        chk(8'(ds), 8'h01);
        slvl = 1'b1;
        step(5);
        $display("reset defaults done");
    endtask : t_reset

    task automatic t_strobe;
        for (int i = 0; i < 4; i++)
        begin
            wreg(3'h0, {5'h0, i[1], 1'b0, i[0]});
            slvl = i[1];
            step(5);
            chk(8'({ds, ws}), i[0] ? 8'h01 : 8'h02);
            slvl = !i[1];
            step(5);
            chk(8'({ds, ws}), 8'h00);
        end
        $display("strobe modes done");
    endtask : t_strobe

    task automatic t_request;
        for (int p = 0; p < 2; p++)
        begin
            wreg(3'h0, p ? 8'hd8 : 8'hc0);
            {auto, apol, rpol} = {1'b1, p[0], p[0]};
            tx = 1'b1;
            step(9);
            chk(8'({r_oe, r_o}), 8'(p));
            chk(8'(ak), 8'h01);
            {auto, tx} = 2'b00;
            step(9);
            chk(8'({r_oe, r_o, ak}), p ? 8'h00 : 8'h02);
        end
        {apol, rpol, rx} = 3'b001;
        wreg(3'h0, 8'hc0);
        step(2);
        chk(8'({r_oe, r_o}), 8'h00);
        rx = 1'b0;
        $display("single request done");
    endtask : t_request

    task automatic t_double;
        wreg(3'h0, 8'hc2);
        tx = 1'b1;
        step(3);
        chk(8'({r_oe, r_o, a_oe, a_o}), 8'h01);
        rx = 1'b1;
        step(6);
        chk(8'({r_oe, r_o, a_oe, a_o, ak}), 8'h00);
        {tx, rx} = 2'b00;
        wreg(3'h0, 8'ha0);
        step(2);
        chk(8'({r_oe, r_o, pin[1]}), 8'h05);
        tx = 1'b1;
        step(2);
        chk(8'({r_oe, r_o, pin[1]}), 8'h00);
        tx = 1'b0;
        $display("double request and open drain done");
    endtask : t_double

    task automatic t_gpio;
        wreg(3'h1, 8'h01);
        wreg(3'h2, 8'h06);
        wreg(3'h3, 8'h02);
        slvl = 1'b0;
        step(5);
        chk(8'({s_o, s_oe, r_oe, a_oe, r_o, a_o, ds}), 8'h24);
        rreg(3'h4, rv);
        chk(8'(rv[2:0]), 8'h02);
        wreg(3'h1, 8'h00);
        slvl = 1'b1;
        $display("port bits done");
    endtask : t_gpio

    task automatic t_stop_wait;
        wreg(3'h0, 8'h80);
        tx = 1'b1;
        step(2);
        stp = 1'b1;
        step(2);
        chk(8'({a_k, r_k, r_oe, r_o, s_k}), 8'h0c);
        {slvl, tx} = 2'b00;
        step(5);
        chk(8'({ds, r_o, r_oe}), 8'h01);
        {stp, slvl, tx} = 3'b011;
        step(5);
        chk(8'({r_k, r_oe, r_o}), 8'h00);
        wt = 1'b1;
        step(3);
        chk(8'({r_k, r_oe, r_o, ds}), 8'h00);
        rreg(3'h4, rv);
        chk(8'(rv[6]), 8'h01);
        wt = 1'b0;
        step(3);
        chk(8'({r_oe, r_o}), 8'h00);
        ce = 1'b0;
        tx = 1'b0;
        step(3);
        chk(8'(r_o), 8'h00);
        ce = 1'b1;
        step(2);
        chk(8'(r_o), 8'h01);
        $display("stop and wait done");
    endtask : t_stop_wait

    task automatic close_out;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    // generous ceiling: the whole sequence needs well under 1000 cycles
    always @(posedge clock_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            close_out();
        end
    end

    initial
    begin
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        t_reset();
        t_strobe();
        t_request();
        t_double();
        t_gpio();
        t_stop_wait();
        close_out();
    end
endmodule : hpsrp_tb_top
